//--- hw/dcc_core.sv
// command decode, power state and bank tracking of the ddr2 device
`timescale 1ns/1ps
`include "dcc_map.svh"
module dcc_core import dcc_pkg::*; (
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic i_cke,
  input wire logic i_cs_n,
  input wire logic i_ras_n,
  input wire logic i_cas_n,
  input wire logic i_we_n,
  input wire logic [2:0] i_ba,
  input wire logic [13:0] i_addr,
  input wire logic [7:0] i_dq,
  input wire logic i_dm,
  input wire logic i_dq_valid,
  input wire logic i_odt,
  input wire logic i_odt_en,
  input wire logic [2:0] i_add_lat,
  output logic [1:0] o_power_state,
  output logic [7:0] o_bank_open,
  output logic o_rd_go,
  output logic o_wr_go,
  output logic [2:0] o_acc_bank,
  output logic [9:0] o_acc_col,
  output logic o_acc_ap,
  output logic o_mr_strobe,
  output logic [2:0] o_mr_sel,
  output logic [13:0] o_mr_value,
  output logic o_wr_strobe,
  output logic [7:0] o_wr_data,
  output logic o_odt_on,
  output logic o_read_ok,
  output logic o_illegal
);
  // two-stage synchronisers on every pin except i_odt_en and i_add_lat, first stage read only by the second
  logic [32:0] sync1_ff;
  logic [32:0] sync2_ff;
  // reset to idle pin levels, so no false clock-enable fall or command follows reset
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      sync1_ff <= `DCC_PIN_IDLE;
      sync2_ff <= `DCC_PIN_IDLE;
    end else begin
      sync1_ff <= {i_cke, i_cs_n, i_ras_n, i_cas_n, i_we_n, i_ba, i_addr, i_dq, i_dm, i_dq_valid, i_odt};
      sync2_ff <= sync1_ff;
    end
  end
  logic cke, cs_n, ras_n, cas_n, we_n, dm, dq_valid, odt;
  logic [2:0] ba;
  logic [13:0] addr;
  logic [7:0] dq;
  assign {cke, cs_n, ras_n, cas_n, we_n, ba, addr, dq, dm, dq_valid, odt} = sync2_ff;

  // pin levels to a command code
  function automatic dcc_cmd_e decode(input logic c, input logic r, input logic a, input logic w);
    dcc_cmd_e res;
    res = DCC_CMD_BAD;
    if (c) res = DCC_CMD_DESEL;
    else begin
      unique case ({r, a, w})
        3'h7: res = DCC_CMD_NOP;
        3'h0: res = DCC_CMD_MRS;
        3'h1: res = DCC_CMD_REF;
        3'h2: res = DCC_CMD_PRE;
        3'h3: res = DCC_CMD_ACT;
        3'h4: res = DCC_CMD_WR;
        3'h5: res = DCC_CMD_RD;
        default: res = DCC_CMD_BAD;
      endcase
    end
    return res;
  endfunction

  dcc_state_s st_ff;
  dcc_state_s nxt_st;
  dcc_cmd_e cmd;
  logic quiet;
  logic busy_any;
  assign cmd = decode(cs_n, ras_n, cas_n, we_n);
  assign quiet = (cmd == DCC_CMD_DESEL) || (cmd == DCC_CMD_NOP);
  assign busy_any = (st_ff.busy != 4'h0) || (st_ff.al_rd != 7'h0) || (st_ff.al_wr != 7'h0);

  // one next-state process covers power state, banks, latency pipe and data
  always_comb begin
    nxt_st = st_ff;
    nxt_st.cke_prev = cke;
    nxt_st.mr_strobe = 1'b0;
    nxt_st.rd_go = 1'b0;
    nxt_st.wr_go = 1'b0;
    nxt_st.wr_strobe = 1'b0;
    nxt_st.illegal = 1'b0;
    nxt_st.busy = (st_ff.busy != 4'h0) ? st_ff.busy - 4'h1 : 4'h0;
    nxt_st.xsrd = (st_ff.xsrd != 8'h0) ? st_ff.xsrd - 8'h1 : 8'h0;
    // additive latency pipe, stage 0 is the internal registration point
    nxt_st.al_rd = {1'b0, st_ff.al_rd[6:1]};
    nxt_st.al_wr = {1'b0, st_ff.al_wr[6:1]};
    nxt_st.al_addr = {14'h0, st_ff.al_addr[6:1]};
    if (st_ff.al_rd[0] || st_ff.al_wr[0]) begin
      nxt_st.rd_go = st_ff.al_rd[0];
      nxt_st.wr_go = st_ff.al_wr[0];
      nxt_st.acc_bank = st_ff.al_addr[0][13:11];
      nxt_st.acc_col = st_ff.al_addr[0][9:0];
      nxt_st.acc_ap = st_ff.al_addr[0][`DCC_AP_BIT];
      nxt_st.busy = `DCC_BURST_CLKS;
      // auto-precharge closes the row in the same cycle the access registers
      if (st_ff.al_addr[0][`DCC_AP_BIT]) nxt_st.bank_open[st_ff.al_addr[0][13:11]] = 1'b0;
    end
    // masked data is dropped and the location keeps its old contents
    if (dq_valid && !dm) begin
      nxt_st.wr_strobe = 1'b1;
      nxt_st.wr_data = dq;
    end
    // odt follows its pin while i_odt_en is high, except in self refresh, never steers state
    nxt_st.odt_on = odt && i_odt_en && (st_ff.pst != DCC_ST_SELF_REF);
    unique case (st_ff.pst)
      DCC_ST_NORMAL: begin
        if (st_ff.cke_prev && cke) begin
          // deselect and nop leave everything running
          unique case (cmd)
            DCC_CMD_DESEL, DCC_CMD_NOP: ;
            DCC_CMD_MRS: begin
              if (st_ff.bank_open != 8'h0) nxt_st.illegal = 1'b1;
              else begin
                nxt_st.mode[ba[1:0]] = addr;
                nxt_st.mr_sel = ba;
                nxt_st.mr_strobe = 1'b1;
                nxt_st.busy = `DCC_BURST_CLKS;
              end
            end
            DCC_CMD_REF: if (st_ff.bank_open != 8'h0) nxt_st.illegal = 1'b1;
            DCC_CMD_PRE: begin
              if (addr[`DCC_AP_BIT]) nxt_st.bank_open = 8'h0;
              else nxt_st.bank_open[ba] = 1'b0;
              nxt_st.busy = `DCC_BURST_CLKS;
            end
            DCC_CMD_ACT: begin
              if (st_ff.bank_open[ba]) nxt_st.illegal = 1'b1;
              else begin
                nxt_st.bank_open[ba] = 1'b1;
                nxt_st.row[ba] = addr;
              end
            end
            DCC_CMD_RD, DCC_CMD_WR: begin
              if (st_ff.xsrd != 8'h0 && cmd == DCC_CMD_RD) nxt_st.illegal = 1'b1;
              else begin
                nxt_st.al_rd[i_add_lat] = (cmd == DCC_CMD_RD);
                nxt_st.al_wr[i_add_lat] = (cmd == DCC_CMD_WR);
                nxt_st.al_addr[i_add_lat] = {ba, addr[`DCC_AP_BIT:0]};
              end
            end
            default: nxt_st.illegal = 1'b1;
          endcase
        end else if (st_ff.cke_prev && !cke) begin
          if (busy_any) nxt_st.illegal = 1'b1;
          else if (cmd == DCC_CMD_REF && st_ff.bank_open == 8'h0) nxt_st.pst = DCC_ST_SELF_REF;
          else if (quiet) nxt_st.pst = (st_ff.bank_open != 8'h0) ? DCC_ST_ACT_PD : DCC_ST_PRE_PD;
          else nxt_st.illegal = 1'b1;
        end else if (!cke) nxt_st.illegal = 1'b1;
      end
      DCC_ST_ACT_PD, DCC_ST_PRE_PD: begin
        // no refresh runs here; the controller bounds the stay
        if (cke) begin
          nxt_st.pst = DCC_ST_NORMAL;
          if (!quiet) nxt_st.illegal = 1'b1;
          if (!i_odt_en) nxt_st.odt_on = 1'b0;
        end
      end
      DCC_ST_SELF_REF: begin
        if (cke) begin
          nxt_st.pst = DCC_ST_NORMAL;
          nxt_st.xsrd = `DCC_TXSRD_CLKS;
          if (!quiet) nxt_st.illegal = 1'b1;
        end
      end
    endcase
  end

  // async exit: cke level alone releases self refresh, no clock history needed
  logic sr_exit;
  assign sr_exit = (st_ff.pst == DCC_ST_SELF_REF) && cke;

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) st_ff <= '0;
    else st_ff <= nxt_st;
  end

  assign o_power_state = sr_exit ? DCC_ST_NORMAL : st_ff.pst;
  assign o_bank_open = st_ff.bank_open;
  assign o_rd_go = st_ff.rd_go;
  assign o_wr_go = st_ff.wr_go;
  assign o_acc_bank = st_ff.acc_bank;
  assign o_acc_col = st_ff.acc_col;
  assign o_acc_ap = st_ff.acc_ap;
  assign o_mr_strobe = st_ff.mr_strobe;
  assign o_mr_sel = st_ff.mr_sel;
  assign o_mr_value = st_ff.mode[st_ff.mr_sel[1:0]];
  assign o_wr_strobe = st_ff.wr_strobe;
  assign o_wr_data = st_ff.wr_data;
  assign o_odt_on = st_ff.odt_on;
  assign o_read_ok = (st_ff.xsrd == 8'h0);
  assign o_illegal = st_ff.illegal;

  // checks next to the logic
  self_ref_idle_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (st_ff.pst == DCC_ST_NORMAL && nxt_st.pst == DCC_ST_SELF_REF) |-> st_ff.bank_open == 8'h0)
    else $error("self refresh entered with open bank");
  pd_kind_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
    ($rose(st_ff.pst == DCC_ST_ACT_PD)) |-> st_ff.bank_open != 8'h0)
    else $error("active power-down without open bank");
  odt_self_ref_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
    ($past(st_ff.pst) == DCC_ST_SELF_REF && st_ff.pst == DCC_ST_SELF_REF) |-> !st_ff.odt_on)
    else $error("odt active in self refresh");
  xsrd_load_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (st_ff.pst == DCC_ST_SELF_REF && cke) |=> (st_ff.xsrd == 8'hc8) ##200 o_read_ok)
    else $error("read hold-off after self refresh wrong");
  al_delay_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (st_ff.pst == DCC_ST_NORMAL && st_ff.cke_prev && cke && cmd == DCC_CMD_RD && o_read_ok && i_add_lat == 3'h0)
    |=> ##1 o_rd_go)
    else $error("read not registered after additive latency");
  mask_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (dq_valid && dm) |=> !o_wr_strobe)
    else $error("masked data written");
  act_open_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (st_ff.pst == DCC_ST_NORMAL && st_ff.cke_prev && cke && cmd == DCC_CMD_ACT && !st_ff.bank_open[ba])
    |=> st_ff.bank_open[$past(ba)])
    else $error("activate did not open bank");
  nop_keeps_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (st_ff.pst == DCC_ST_NORMAL && st_ff.cke_prev && cke && quiet && !busy_any)
    |=> st_ff.bank_open == $past(st_ff.bank_open) && !o_mr_strobe)
    else $error("nop changed state");

  // decode windows shared by the checks below
  logic both_high;
  logic cke_fall;
  assign both_high = (st_ff.pst == DCC_ST_NORMAL) && st_ff.cke_prev && cke;
  assign cke_fall = (st_ff.pst == DCC_ST_NORMAL) && st_ff.cke_prev && !cke;

  // refresh on a clean fall with all banks idle enters self refresh
  sr_entry_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (cke_fall && cmd == DCC_CMD_REF && st_ff.bank_open == 8'h0 && !busy_any) |=> st_ff.pst == DCC_ST_SELF_REF)
    else $error("self refresh not entered");

  // quiet fall with idle banks is precharge power-down
  pre_pd_entry_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (cke_fall && quiet && st_ff.bank_open == 8'h0 && !busy_any) |=> st_ff.pst == DCC_ST_PRE_PD)
    else $error("precharge power-down not entered");

  // quiet fall with an open row is active power-down
  act_pd_entry_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (cke_fall && quiet && st_ff.bank_open != 8'h0 && !busy_any) |=> st_ff.pst == DCC_ST_ACT_PD)
    else $error("active power-down not entered");

  // low clock enable keeps power-down and leaves the open rows alone
  pd_hold_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
    ((st_ff.pst == DCC_ST_ACT_PD || st_ff.pst == DCC_ST_PRE_PD) && !cke)
    |=> st_ff.pst == $past(st_ff.pst) && $stable(st_ff.bank_open))
    else $error("power-down not maintained");

  // rising clock enable leaves power-down
  pd_exit_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
    ((st_ff.pst == DCC_ST_ACT_PD || st_ff.pst == DCC_ST_PRE_PD) && cke) |=> st_ff.pst == DCC_ST_NORMAL)
    else $error("power-down not left");

  // low clock enable keeps self refresh
  sr_hold_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (st_ff.pst == DCC_ST_SELF_REF && !cke) |=> st_ff.pst == DCC_ST_SELF_REF)
    else $error("self refresh not maintained");

  // exit shows on the state output before any further edge
  sr_exit_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (st_ff.pst == DCC_ST_SELF_REF && cke) |-> o_power_state == DCC_ST_NORMAL)
    else $error("self refresh exit not reported");

  // a fall while work is pending is refused and the state stays normal
  busy_fall_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (cke_fall && busy_any) |=> o_illegal && st_ff.pst == DCC_ST_NORMAL)
    else $error("power state change while busy");

  // mode set with idle banks loads the register chosen by the bank address
  mrs_load_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (both_high && cmd == DCC_CMD_MRS && st_ff.bank_open == 8'h0)
    |=> o_mr_strobe && o_mr_sel == $past(ba) && o_mr_value == $past(addr))
    else $error("mode register not loaded");

  // mode set with an open row is refused
  mrs_refused_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (both_high && cmd == DCC_CMD_MRS && st_ff.bank_open != 8'h0) |=> o_illegal && !o_mr_strobe)
    else $error("mode set with open bank accepted");

  // activate to a bank that already holds a row is refused
  act_refused_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (both_high && cmd == DCC_CMD_ACT && st_ff.bank_open[ba]) |=> o_illegal)
    else $error("activate to open bank accepted");

  // read inside the hold-off after self refresh is refused
  rd_hold_off_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (both_high && cmd == DCC_CMD_RD && !o_read_ok) |=> o_illegal)
    else $error("read accepted during hold-off");

  // auto-precharge closes the row in the cycle the access registers
  ap_close_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
    ((o_rd_go || o_wr_go) && o_acc_ap) |-> !o_bank_open[o_acc_bank])
    else $error("auto-precharge left row open");

  // an unmasked beat is handed on with its data
  wr_data_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (dq_valid && !dm) |=> o_wr_strobe && o_wr_data == $past(dq))
    else $error("unmasked data not written");

  // deselect starts nothing and raises no fault
  desel_idle_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (both_high && cmd == DCC_CMD_DESEL) |=> !o_illegal && !o_mr_strobe)
    else $error("deselect started work");

  // precharge of one bank closes that bank
  pre_close_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (both_high && cmd == DCC_CMD_PRE && !addr[`DCC_AP_BIT]) |=> !st_ff.bank_open[$past(ba)])
    else $error("precharge left bank open");
endmodule

//--- hw/dcc_map.svh
// constants for the ddr2 cke and command control block
`ifndef DCC_MAP_SVH
`define DCC_MAP_SVH
`define DCC_NBANK 8
`define DCC_ROW_W 14
`define DCC_COL_W 10
`define DCC_AP_BIT 10
`define DCC_MR_W 14
`define DCC_AL_MAX 6
`define DCC_BURST_CLKS 4'h2
`define DCC_TXSRD_CLKS 8'hc8
`define DCC_CKE_MIN_CLKS 2'h3
`define DCC_PIN_IDLE 33'h1f0000000
`endif

//--- hw/dcc_pkg.sv
// types for the ddr2 cke and command control block
package dcc_pkg;
  typedef enum logic [1:0] {DCC_ST_NORMAL, DCC_ST_ACT_PD, DCC_ST_PRE_PD, DCC_ST_SELF_REF} dcc_pstate_e;
  typedef enum logic [3:0] {
    DCC_CMD_DESEL, DCC_CMD_NOP, DCC_CMD_MRS, DCC_CMD_REF, DCC_CMD_PRE, DCC_CMD_ACT,
    DCC_CMD_WR, DCC_CMD_RD, DCC_CMD_BAD
  } dcc_cmd_e;
  typedef struct packed {
    dcc_pstate_e pst;
    logic cke_prev;
    logic [7:0] bank_open;
    logic [7:0][13:0] row;
    logic [6:0] al_rd;
    logic [6:0] al_wr;
    logic [6:0][13:0] al_addr;
    logic [3:0] busy;
    logic [7:0] xsrd;
    logic [3:0][13:0] mode;
    logic [2:0] mr_sel;
    logic mr_strobe;
    logic rd_go;
    logic wr_go;
    logic [2:0] acc_bank;
    logic [9:0] acc_col;
    logic acc_ap;
    logic wr_strobe;
    logic [7:0] wr_data;
    logic illegal;
    logic odt_on;
  } dcc_state_s;
endpackage

//--- test/dcc_ctrl_model.sv
// controller-side model driving the command, clock-enable and data pins
`timescale 1ns/1ps
module dcc_ctrl_model (
  input wire logic i_clock,
  output logic o_cke,
  output logic o_cs_n,
  output logic o_ras_n,
  output logic o_cas_n,
  output logic o_we_n,
  output logic [2:0] o_ba,
  output logic [13:0] o_addr,
  output logic [7:0] o_dq,
  output logic o_dm,
  output logic o_dq_valid
);
  integer seed = 32'h95adbd26;
  // pins launched 10 ns after the edge and held a full cycle
  task automatic send(input logic cke, input logic [3:0] c, input logic [2:0] ba, input logic [13:0] a,
                      input logic dv = 1'b0, input logic [7:0] d = 8'h0, input logic m = 1'b0);
    @(posedge i_clock);
    #10;
    o_cke = cke;
    {o_cs_n, o_ras_n, o_cas_n, o_we_n} = c;
    o_ba = ba;
    o_addr = a;
    o_dq = dv ? d : ~o_dq; // released bus toggles so a stale beat never matches
    o_dm = dv ? m : 1'($random(seed));
    o_dq_valid = dv;
  endtask
  // idle edges keep the current clock-enable level
  task automatic nops(input int n);
    repeat (n) send(o_cke, 4'h7, 3'($random(seed)), 14'($random(seed)));
  endtask
  // drain busy work, move cke with c, then hold it for three registered edges
  task automatic cke_move(input logic lvl, input logic [3:0] c);
    nops(4);
    send(lvl, c, 3'h0, 14'h0);
    nops(2);
  endtask
  // idle pins at time zero, clock enable high
  initial begin
    o_cke = 1'b1;
    {o_cs_n, o_ras_n, o_cas_n, o_we_n} = 4'hf;
    o_ba = 3'h0;
    o_addr = 14'h0;
    o_dq = 8'h0;
    o_dm = 1'b0;
    o_dq_valid = 1'b0;
  end
endmodule

//--- test/ddr2_cke_and_command_control_tb_top.sv
// self-checking bench for the ddr2 cke and command control block
`timescale 1ns/1ps
module ddr2_cke_and_command_control_tb_top import dcc_pkg::*;;
  localparam logic [3:0] c_nop = 4'h7, c_des = 4'hf, c_mrs = 4'h0, c_ref = 4'h1, c_act = 4'h3, c_wr = 4'h4;
  localparam logic [3:0] c_rd = 4'h5;
  logic i_clock, i_rstn, i_cke, i_cs_n, i_ras_n, i_cas_n, i_we_n, i_dm, i_dq_valid, i_odt, i_odt_en;
  logic [2:0] i_ba, i_add_lat, o_acc_bank, o_mr_sel, b, al;
  logic [13:0] i_addr, o_mr_value;
  logic [7:0] i_dq, o_bank_open, o_wr_data, wd, last_wr;
  logic [1:0] o_power_state;
  logic [9:0] o_acc_col, col;
  logic o_rd_go, o_wr_go, o_acc_ap, o_mr_strobe, o_wr_strobe, o_odt_on, o_read_ok, o_illegal;
  integer seed = 32'h95adbd26;
  int mismatches = 0, num_checks = 0, cycles = 0, strobes = 0, n;
  dcc_core u_dcc_core (.i_clock, .i_rstn, .i_cke, .i_cs_n, .i_ras_n, .i_cas_n, .i_we_n, .i_ba, .i_addr, .i_dq, .i_dm,
    .i_dq_valid, .i_odt, .i_odt_en, .i_add_lat, .o_power_state, .o_bank_open, .o_rd_go, .o_wr_go, .o_acc_bank,
    .o_acc_col, .o_acc_ap, .o_mr_strobe, .o_mr_sel, .o_mr_value, .o_wr_strobe, .o_wr_data, .o_odt_on, .o_read_ok,
    .o_illegal);
  dcc_ctrl_model u_dcc_ctrl_model (.i_clock, .o_cke(i_cke), .o_cs_n(i_cs_n), .o_ras_n(i_ras_n), .o_cas_n(i_cas_n),
    .o_we_n(i_we_n), .o_ba(i_ba), .o_addr(i_addr), .o_dq(i_dq), .o_dm(i_dm), .o_dq_valid(i_dq_valid));
  // 10 mhz clock
  initial begin
    i_clock = 1'b0;
    forever #50 i_clock = ~i_clock;
  end
  // counts unmasked beats and cuts a hang short; sampled after the edge settles
  always @(posedge i_clock) begin
    #5;
    cycles++;
    if (o_wr_strobe === 1'b1) begin
      strobes++;
      last_wr = o_wr_data;
    end
    if (cycles == 3000) begin
      mismatches++;
      conclude();
    end
  end
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // main sequence: bank tracking, power-down, accesses, mode set, self refresh
  initial begin
    i_rstn = 1'b0;
    i_odt = 1'b1;
    i_odt_en = 1'b1;
    i_add_lat = 3'h0;
    repeat (2) @(posedge i_clock);
    #10;
    i_rstn = 1'b1;
    check("power_state", o_power_state, DCC_ST_NORMAL);
    check("bank_open", o_bank_open, 8'h0);
    b = 3'($random(seed));
    u_dcc_ctrl_model.send(1'b1, c_act, b, 14'($random(seed)));
    u_dcc_ctrl_model.nops(4);
    check("bank_open", o_bank_open, 8'h1 << b);
    check("odt_on", o_odt_on, 1'b1);
    i_odt = 1'($random(seed));
    i_odt_en = 1'($random(seed));
    u_dcc_ctrl_model.nops(4);
    check("odt_on", o_odt_on, i_odt & i_odt_en);
    i_odt = 1'b1;
    i_odt_en = 1'b1;
    u_dcc_ctrl_model.send(1'b1, c_act, b, 14'h0);
    u_dcc_ctrl_model.nops(3);
    check("illegal", o_illegal, 1'b1);
    u_dcc_ctrl_model.cke_move(1'b0, c_nop);
    u_dcc_ctrl_model.nops(3);
    check("power_state", o_power_state, DCC_ST_ACT_PD);
    u_dcc_ctrl_model.cke_move(1'b1, c_des);
    u_dcc_ctrl_model.nops(3);
    check("power_state", o_power_state, DCC_ST_NORMAL);
    $display("activate and power-down test done");
    // read without, then write with auto-precharge; random latency and column
    for (int k = 0; k < 2; k++) begin
      al = 3'({$random(seed)} % 7);
      col = 10'($random(seed));
      i_add_lat = al;
      u_dcc_ctrl_model.send(1'b1, k ? c_wr : c_rd, b, {3'h0, k[0], col});
      for (n = 0; n < 14 && o_rd_go !== 1'b1 && o_wr_go !== 1'b1; n++)
        if (k && (n == al || n == al + 1)) begin
          wd = 8'($random(seed));
          u_dcc_ctrl_model.send(1'b1, c_nop, 3'h0, 14'h0, 1'b1, wd, n == al);
        end else u_dcc_ctrl_model.send(1'b1, n[0] ? c_des : c_nop, 3'h0, 14'h0);
      check("go_latency", 16'(n), 16'(4 + al));
      check("wr_go", o_wr_go, k[0]);
      check("acc_bank", o_acc_bank, b);
      check("acc_col", o_acc_col, col);
      check("acc_ap", o_acc_ap, k[0]);
      u_dcc_ctrl_model.nops(8);
      check("bank_open", o_bank_open[b], !k[0]);
    end
    check("strobes", 16'(strobes), 16'h1);
    check("wr_data", last_wr, wd);
    u_dcc_ctrl_model.send(1'b1, c_mrs, {1'b0, b[1:0]}, {2'h0, col, 2'h0});
    u_dcc_ctrl_model.nops(3);
    check("mr_strobe", o_mr_strobe, 1'b1);
    check("mr_sel", o_mr_sel, {1'b0, b[1:0]});
    u_dcc_ctrl_model.nops(1);
    check("mr_value", o_mr_value, {2'h0, col, 2'h0});
    $display("access and mode set test done");
    u_dcc_ctrl_model.cke_move(1'b0, c_des);
    u_dcc_ctrl_model.nops(3);
    check("power_state", o_power_state, DCC_ST_PRE_PD);
    u_dcc_ctrl_model.cke_move(1'b1, c_nop);
    u_dcc_ctrl_model.cke_move(1'b0, c_ref);
    u_dcc_ctrl_model.nops(3);
    check("power_state", o_power_state, DCC_ST_SELF_REF);
    check("odt_on", o_odt_on, 1'b0);
    u_dcc_ctrl_model.cke_move(1'b1, c_des);
    u_dcc_ctrl_model.nops(1);
    check("power_state", o_power_state, DCC_ST_NORMAL);
    check("read_ok", o_read_ok, 1'b0);
    u_dcc_ctrl_model.nops(188);
    check("read_ok", o_read_ok, 1'b0);
    u_dcc_ctrl_model.nops(20);
    check("read_ok", o_read_ok, 1'b1);
    $display("self refresh test done");
    conclude();
  end
endmodule
